// file: rtl/mpco_map.svh
// Register offsets, field positions and reset values of the modem pin override block
`ifndef MPCO_MAP_SVH
`define MPCO_MAP_SVH

// ------------------------------------
// Register offsets (byte addresses, low address bits only)
// ------------------------------------
`define MPCO_ADDR_W        8
`define MPCO_DRIVE_OFS     8'h0c
`define MPCO_SWAP_OFS      8'h10

// ------------------------------------
// Reset values
// ------------------------------------
`define MPCO_DRIVE_RST     32'h0000_0002
`define MPCO_SWAP_RST      32'h0000_0000

// ------------------------------------
// Field positions of the drive control register
// ------------------------------------
`define MPCO_BIT_IRQ_EN    0
`define MPCO_BIT_DIRECT    1
`define MPCO_BIT_NEG_LVL   2
`define MPCO_BIT_POS_LVL   3
`define MPCO_NEG_SEL_LSB   4
`define MPCO_POS_SEL_LSB   6
`define MPCO_SEL_W         2

// ------------------------------------
// Field position of the swap register
// ------------------------------------
`define MPCO_BIT_SWAP      0

// ------------------------------------
// AHB encodings used by the slave
// ------------------------------------
`define MPCO_HSIZE_BYTE    3'h0
`define MPCO_HSIZE_HALF    3'h1

`endif

// file: rtl/mpco_pin_mux.sv
// Drive selection for one physical power/clock pad
`timescale 1ns/1ps

module mpco_pin_mux
    import mpco_pkg::*;
(
    input  wire logic          direct_en,  // Software owns the pad
    input  wire logic [1:0]    sel,        // Software drive selection code
    input  wire mpco_pin_drv_t proto_drv,  // Drive asked by protocol logic
    output mpco_pin_drv_t      drv         // Resulting pad drive
);

    // ------------------------------------
    // Selection decode
    // ------------------------------------
    // Low bit set floats the pad; otherwise the high bit is the level
    function automatic mpco_pin_drv_t decode_sel(input logic [1:0] code);
        mpco_pin_drv_t d;
        d.oe  = ~code[0];
        d.out = code[1] & ~code[0];
        return d;
    endfunction : decode_sel

    // Protocol logic owns the pad unless software took it
    always_comb begin
        if (direct_en) begin
            drv = decode_sel(sel);
        end else begin
            drv = proto_drv;
        end
    end

endmodule : mpco_pin_mux

// file: rtl/mpco_pin_override.sv
// Drive control register and pin override of the software modem power/clock pads
//
// Operation
// - Drive control register reachable over the AHB bus
// - Direct off: protocol logic drives positive pin
// - Direct off: protocol logic drives negative pin
// - Direct on: software owns both pins
// - Positive select: X1 float, 00 low, 10 high
// - Negative select: X1 float, 00 low, 10 high
// - Swap: positive select drives negative pin
// - Swap: negative select drives positive pin
// - Bit 3 reads positive pin, swapped negative
// - Bit 2 reads negative pin, swapped positive
// - Bit 0 gates status flag onto interrupt
`timescale 1ns/1ps
`include "mpco_map.svh"

module mpco_pin_override
    import mpco_pkg::*;
(
    input  wire logic          clk,                   // System clock, 10 MHz
    input  wire logic          rst_n,                 // Synchronous reset, active low
    input  wire logic          hsel,                  // AHB slave select
    input  wire logic [31:0]   haddr,                 // AHB address
    input  wire logic [1:0]    htrans,                // AHB transfer type
    input  wire logic          hwrite,                // AHB write strobe
    input  wire logic [2:0]    hsize,                 // AHB transfer size
    input  wire logic          hready,                // AHB bus ready in
    input  wire logic [31:0]   hwdata,                // AHB write data
    output logic               hreadyout,             // AHB ready out
    output logic               hresp,                 // AHB response
    output logic [31:0]        hrdata,                // AHB read data
    input  wire mpco_pin_drv_t proto_pos_drv,         // Protocol drive, positive pin
    input  wire mpco_pin_drv_t proto_neg_drv,         // Protocol drive, negative pin
    output logic               proto_pos_level,       // Positive pin level to protocol
    output logic               proto_neg_level,       // Negative pin level to protocol
    input  wire logic          monitored_status_flag, // Status flag from protocol
    output logic               modem_irq,             // Modem interrupt, active high
    input  wire logic          power_clock_pos_pin_in,  // Positive pad input
    output logic               power_clock_pos_pin_out, // Positive pad output level
    output logic               power_clock_pos_pin_oe,  // Positive pad output enable
    input  wire logic          power_clock_neg_pin_in,  // Negative pad input
    output logic               power_clock_neg_pin_out, // Negative pad output level
    output logic               power_clock_neg_pin_oe   // Negative pad output enable
);

    // ------------------------------------
    // Declarations
    // ------------------------------------
    mpco_ctrl_t    ctrl_reg;          // Software control state
    mpco_ctrl_t    ctrl_next;         // Control state after this cycle's write
    mpco_aphase_t  aph_reg;           // Captured address phase
    mpco_aphase_t  aph_next;          // Address phase seen this cycle
    logic [31:0]   hrdata_reg;        // Registered read data
    logic [31:0]   hrdata_next;       // Read data for the next data phase
    logic [1:0]    pos_sync_reg;      // Positive pad synchroniser
    logic [1:0]    neg_sync_reg;      // Negative pad synchroniser
    logic          pos_level;         // Synchronised positive pad level
    logic          neg_level;         // Synchronised negative pad level
    logic          pos_sel_level;     // Level seen by the positive selection
    logic          neg_sel_level;     // Level seen by the negative selection
    mpco_pin_drv_t pos_drv;           // Resulting positive pad drive
    mpco_pin_drv_t neg_drv;           // Resulting negative pad drive
    mpco_pin_drv_t proto_to_pos;      // Protocol drive routed to positive pad
    mpco_pin_drv_t proto_to_neg;      // Protocol drive routed to negative pad
    logic [1:0]    sel_to_pos;        // Selection routed to positive pad
    logic [1:0]    sel_to_neg;        // Selection routed to negative pad
    logic          irq_reg;           // Registered interrupt
    logic          wr_drive;          // Write to drive control register
    logic          wr_swap;           // Write to swap register
    localparam logic [31:0] DRIVE_RST = `MPCO_DRIVE_RST; // Drive reset word
    localparam logic [31:0] SWAP_RST  = `MPCO_SWAP_RST;  // Swap reset word

    // ------------------------------------
    // Helper functions
    // ------------------------------------
    // True when an access of this size and alignment touches byte lane 0
    function automatic logic covers_lane0(input logic [2:0] size, input logic [1:0] a);
        logic hit;
        hit = 1'b1;
        if (size == `MPCO_HSIZE_BYTE) begin
            hit = (a == 2'b00);
        end else if (size == `MPCO_HSIZE_HALF) begin
            hit = ~a[1];
        end
        return hit;
    endfunction : covers_lane0

    // Drive control word as software reads it, unused bits forced to zero
    function automatic logic [31:0] drive_word(input mpco_ctrl_t c,
                                               input logic       pl,
                                               input logic       nl);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`MPCO_POS_SEL_LSB +: `MPCO_SEL_W] = c.pos_pin_drive_select;
        w[`MPCO_NEG_SEL_LSB +: `MPCO_SEL_W] = c.neg_pin_drive_select;
        w[`MPCO_BIT_POS_LVL] = pl;
        w[`MPCO_BIT_NEG_LVL] = nl;
        w[`MPCO_BIT_DIRECT]  = c.direct_pin_control_enable;
        w[`MPCO_BIT_IRQ_EN]  = c.status_flag_irq_enable;
        return w;
    endfunction : drive_word

    // ------------------------------------
    // AHB address phase
    // ------------------------------------
    // Only NONSEQ and SEQ transfers are taken; IDLE and BUSY are ignored
    always_comb begin
        aph_next.valid = hsel & hready & htrans[1];
        aph_next.write = hwrite;
        aph_next.addr  = haddr[`MPCO_ADDR_W-1:0];
        aph_next.lane0 = covers_lane0(hsize, haddr[1:0]);
    end

    // Address phase capture for the following data phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aph_reg <= '0;
        end else begin
            aph_reg <= aph_next;
        end
    end

    // Slave never inserts wait states and never errors; unmapped reads give zero
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------
    // Register writes
    // ------------------------------------
    // Write data arrives in the data phase; only lane 0 carries used bits
    assign wr_drive = aph_reg.valid & aph_reg.write & aph_reg.lane0
                    & (aph_reg.addr == `MPCO_DRIVE_OFS);
    assign wr_swap  = aph_reg.valid & aph_reg.write & aph_reg.lane0
                    & (aph_reg.addr == `MPCO_SWAP_OFS);

    // Next control state; level bits are read-only and bits 31:8 dropped
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_drive) begin
            ctrl_next.pos_pin_drive_select =
                hwdata[`MPCO_POS_SEL_LSB +: `MPCO_SEL_W];
            ctrl_next.neg_pin_drive_select =
                hwdata[`MPCO_NEG_SEL_LSB +: `MPCO_SEL_W];
            ctrl_next.direct_pin_control_enable = hwdata[`MPCO_BIT_DIRECT];
            ctrl_next.status_flag_irq_enable    = hwdata[`MPCO_BIT_IRQ_EN];
        end
        if (wr_swap) begin
            ctrl_next.pin_swap_select = hwdata[`MPCO_BIT_SWAP];
        end
    end

    // Control register; reset leaves both pads under software, driven low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg.pos_pin_drive_select      <= DRIVE_RST[`MPCO_POS_SEL_LSB +: 2];
            ctrl_reg.neg_pin_drive_select      <= DRIVE_RST[`MPCO_NEG_SEL_LSB +: 2];
            ctrl_reg.direct_pin_control_enable <= DRIVE_RST[`MPCO_BIT_DIRECT];
            ctrl_reg.status_flag_irq_enable    <= DRIVE_RST[`MPCO_BIT_IRQ_EN];
            ctrl_reg.pin_swap_select           <= SWAP_RST[`MPCO_BIT_SWAP];
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ------------------------------------
    // Register reads
    // ------------------------------------
    // Read data is built from the next control state, so a read right
    // after a write to the same register already sees the new value
    always_comb begin
        hrdata_next = 32'h0000_0000;
        if (aph_next.valid && !aph_next.write) begin
            case (aph_next.addr)
                `MPCO_DRIVE_OFS: begin
                    hrdata_next = drive_word(ctrl_next, pos_sel_level,
                                             neg_sel_level);
                end
                `MPCO_SWAP_OFS: begin
                    hrdata_next[`MPCO_BIT_SWAP] = ctrl_next.pin_swap_select;
                end
                default: begin
                    hrdata_next = 32'h0000_0000;   // Unmapped reads as zero
                end
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata_reg <= 32'h0000_0000;
        end else begin
            hrdata_reg <= hrdata_next;
        end
    end

    assign hrdata = hrdata_reg;

    // ----------------------------------------------------------------
    // Pad input synchronisers
    // ----------------------------------------------------------------
    // Pads are asynchronous to clk; stage 0 feeds only stage 1
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_sync_reg <= 2'b00;
            neg_sync_reg <= 2'b00;
        end else begin
            pos_sync_reg <= {pos_sync_reg[0], power_clock_pos_pin_in};
            neg_sync_reg <= {neg_sync_reg[0], power_clock_neg_pin_in};
        end
    end

    assign pos_level = pos_sync_reg[1];
    assign neg_level = neg_sync_reg[1];

    // Read-back follows the swap: each level bit tracks its own selection
    always_comb begin
        if (ctrl_reg.pin_swap_select) begin
            pos_sel_level = neg_level;
            neg_sel_level = pos_level;
        end else begin
            pos_sel_level = pos_level;
            neg_sel_level = neg_level;
        end
    end

    // Protocol logic sees levels in its own orientation
    assign proto_pos_level = pos_sel_level;
    assign proto_neg_level = neg_sel_level;

    // ----------------------------------------------------------------
    // Pad drive routing
    // ----------------------------------------------------------------
    // Swap exchanges both the software selections and the protocol drives,
    // so a board with crossed pads is fixed in one place
    always_comb begin
        if (ctrl_reg.pin_swap_select) begin
            sel_to_pos   = ctrl_reg.neg_pin_drive_select;
            sel_to_neg   = ctrl_reg.pos_pin_drive_select;
            proto_to_pos = proto_neg_drv;
            proto_to_neg = proto_pos_drv;
        end else begin
            sel_to_pos   = ctrl_reg.pos_pin_drive_select;
            sel_to_neg   = ctrl_reg.neg_pin_drive_select;
            proto_to_pos = proto_pos_drv;
            proto_to_neg = proto_neg_drv;
        end
    end

    // Positive physical pad
    mpco_pin_mux u_pos_mux (
        .direct_en (ctrl_reg.direct_pin_control_enable),
        .sel       (sel_to_pos),
        .proto_drv (proto_to_pos),
        .drv       (pos_drv)
    );

    // Negative physical pad
    mpco_pin_mux u_neg_mux (
        .direct_en (ctrl_reg.direct_pin_control_enable),
        .sel       (sel_to_neg),
        .proto_drv (proto_to_neg),
        .drv       (neg_drv)
    );

    // Pad outputs registered; costs one cycle of protocol latency but
    // keeps glitches off the transformer primary
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            power_clock_pos_pin_out <= 1'b0;
            power_clock_pos_pin_oe  <= 1'b0;
            power_clock_neg_pin_out <= 1'b0;
            power_clock_neg_pin_oe  <= 1'b0;
        end else begin
            power_clock_pos_pin_out <= pos_drv.out;
            power_clock_pos_pin_oe  <= pos_drv.oe;
            power_clock_neg_pin_out <= neg_drv.out;
            power_clock_neg_pin_oe  <= neg_drv.oe;
        end
    end

    // ----------------------------------------------------------------
    // Status interrupt
    // ----------------------------------------------------------------
    // Flag is a level from protocol logic; enable only gates it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= monitored_status_flag & ctrl_reg.status_flag_irq_enable;
        end
    end

    assign modem_irq = irq_reg;

endmodule : mpco_pin_override

// file: rtl/mpco_pkg.sv
// Types shared by the modem pin override block
package mpco_pkg;

    // ------------------------------------
    // Drive of one pad: level and enable travel together
    // ------------------------------------
    typedef struct packed {
        logic out;                          // Level driven when enabled
        logic oe;                           // High while the pad is driven
    } mpco_pin_drv_t;

    // ------------------------------------
    // Software control state
    // ------------------------------------
    typedef struct packed {
        logic [1:0] pos_pin_drive_select;   // Selection for the positive pin
        logic [1:0] neg_pin_drive_select;   // Selection for the negative pin
        logic       direct_pin_control_enable; // Hand pins to software
        logic       status_flag_irq_enable; // Gate of the status interrupt
        logic       pin_swap_select;        // Exchange the two pins
    } mpco_ctrl_t;

    // ------------------------------------
    // Captured AHB address phase
    // ------------------------------------
    typedef struct packed {
        logic       valid;                  // A transfer is in data phase
        logic       write;                  // Transfer direction
        logic [7:0] addr;                   // Low byte address
        logic       lane0;                  // Access covers byte lane 0
    } mpco_aphase_t;

endpackage : mpco_pkg

// file: verification/mpco_lsd_model.sv
// Line side device model: loads the power/clock pads, drives released ones
`timescale 1ns/1ps

module mpco_lsd_model (
    input  wire logic pos_out,  // Pad level from block
    input  wire logic pos_oe,   // Pad enable from block
    input  wire logic neg_out,  // Pad level from block
    input  wire logic neg_oe,   // Pad enable from block
    input  wire logic lsd_pos,  // Far side level on a released pos pad
    input  wire logic lsd_neg,  // Far side level on a released neg pad
    output logic      pos_pin,  // Resolved positive pad
    output logic      neg_pin   // Resolved negative pad
);
    // Block wins while it drives; a released pad never keeps its old level
    assign pos_pin = pos_oe ? pos_out : lsd_pos;
    assign neg_pin = neg_oe ? neg_out : lsd_neg;
endmodule : mpco_lsd_model

// file: verification/mpco_pin_override_chk.sv
// Port checker of the modem power/clock pin override block
`timescale 1ns/1ps

module mpco_pin_override_chk
    import mpco_pkg::*;
(
    input wire logic          clk,                     // System clock
    input wire logic          rst_n,                   // Sync reset, low
    input wire logic          hsel,                    // Select
    input wire logic [31:0]   haddr,                   // Address
    input wire logic [1:0]    htrans,                  // Transfer type
    input wire logic          hwrite,                  // Direction
    input wire logic [2:0]    hsize,                   // Size
    input wire logic          hready,                  // Ready in
    input wire logic [31:0]   hwdata,                  // Write data
    input wire logic          hreadyout,               // Ready out
    input wire logic          hresp,                   // Response
    input wire logic [31:0]   hrdata,                  // Read data
    input wire mpco_pin_drv_t proto_pos_drv,           // Protocol drive, pos
    input wire mpco_pin_drv_t proto_neg_drv,           // Protocol drive, neg
    input wire logic          monitored_status_flag,   // Status flag
    input wire logic          modem_irq,               // Interrupt
    input wire logic          power_clock_pos_pin_out, // Pos pad level
    input wire logic          power_clock_pos_pin_oe,  // Pos pad enable
    input wire logic          power_clock_neg_pin_out, // Neg pad level
    input wire logic          power_clock_neg_pin_oe   // Neg pad enable
);
    // ------------------------------------
    // Shadow of software state, rebuilt from bus traffic
    // ------------------------------------
    logic       ap_val_reg;  // Data phase pending
    logic       ap_wr_reg;   // Pending transfer writes
    logic       ap_lane_reg; // Pending transfer covers lane 0
    logic [7:0] ap_addr_reg; // Pending low address
    logic [7:0] drv_reg;     // Drive register copy, level bits zero
    logic       swp_reg;     // Swap register copy
    logic [1:0] psel;        // Selection landing on the positive pad
    logic [1:0] nsel;        // Selection landing on the negative pad

    // Address phase capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ap_val_reg <= 1'b0;
        end else begin
            ap_val_reg <= hsel && hready && htrans[1];
        end
        ap_wr_reg   <= hwrite;
        ap_lane_reg <= hsize > 3'h1 || !haddr[1] && (hsize[0] || !haddr[0]);
        ap_addr_reg <= haddr[7:0];
    end

    // Register copy; level bits are not stored since they are read-only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drv_reg <= 8'h02;
            swp_reg <= 1'b0;
        end else if (ap_val_reg && ap_wr_reg && ap_lane_reg) begin
            if (ap_addr_reg == 8'h0c) begin
                drv_reg <= hwdata[7:0] & 8'hf3;
            end
            if (ap_addr_reg == 8'h10) begin
                swp_reg <= hwdata[0];
            end
        end
    end

    // Swap hands each pad the other pad's selection
    assign psel = swp_reg ? drv_reg[5:4] : drv_reg[7:6];
    assign nsel = swp_reg ? drv_reg[7:6] : drv_reg[5:4];

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------
    // Assertions
    // ------------------------------------
    bus_always_ready_a: assert property (hreadyout && !hresp)
        else $error("bus stalled or answered with error");
    drive_readback_a: assert property (ap_val_reg && !ap_wr_reg && ap_addr_reg == 8'h0c |->
        hrdata[31:8] == 24'h0 && hrdata[7:4] == drv_reg[7:4] && hrdata[1:0] == drv_reg[1:0])
        else $error("drive register read back wrong");
    swap_readback_a: assert property (ap_val_reg && !ap_wr_reg && ap_addr_reg == 8'h10 |->
        hrdata == {31'h0, swp_reg}) else $error("swap register read back wrong");
    unmapped_zero_a: assert property (ap_val_reg && !ap_wr_reg && ap_addr_reg == 8'h20 |->
        hrdata == 32'h0) else $error("unmapped read not zero");
    proto_pos_a: assert property (!drv_reg[1] && !swp_reg |=>
        power_clock_pos_pin_oe == $past(proto_pos_drv[0]) && (!power_clock_pos_pin_oe ||
        power_clock_pos_pin_out == $past(proto_pos_drv[1]))) else $error("pos pad not protocol");
    proto_neg_a: assert property (!drv_reg[1] && !swp_reg |=>
        power_clock_neg_pin_oe == $past(proto_neg_drv[0]) && (!power_clock_neg_pin_oe ||
        power_clock_neg_pin_out == $past(proto_neg_drv[1]))) else $error("neg pad not protocol");
    direct_pos_a: assert property (drv_reg[1] |=>
        power_clock_pos_pin_oe == !$past(psel[0]) && (!power_clock_pos_pin_oe ||
        power_clock_pos_pin_out == $past(psel[1]))) else $error("pos pad ignores selection");
    direct_neg_a: assert property (drv_reg[1] |=>
        power_clock_neg_pin_oe == !$past(nsel[0]) && (!power_clock_neg_pin_oe ||
        power_clock_neg_pin_out == $past(nsel[1]))) else $error("neg pad ignores selection");
    irq_gate_a: assert property (1'b1 |=>
        modem_irq == ($past(monitored_status_flag) && $past(drv_reg[0])))
        else $error("interrupt not gated by enable");
endmodule : mpco_pin_override_chk

bind mpco_pin_override mpco_pin_override_chk u_chk (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
    .hreadyout, .hresp, .hrdata, .proto_pos_drv, .proto_neg_drv, .monitored_status_flag,
    .modem_irq, .power_clock_pos_pin_out, .power_clock_pos_pin_oe,
    .power_clock_neg_pin_out, .power_clock_neg_pin_oe
);

// file: verification/tb_top.sv
// Self-checking bench of the modem power/clock pin override block
`timescale 1ns/1ps

module tb_top;
    import mpco_pkg::*;

    // ------------------------------------
    // Signals and model state
    // ------------------------------------
    logic          clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0]   haddr, hwdata, hrdata, rd, wd, r;
    logic [1:0]    htrans;
    logic [2:0]    hsize;
    mpco_pin_drv_t pdrv, ndrv;                  // Protocol drives
    logic          flag, irq, pp_lvl, pn_lvl;   // Flag and block outputs
    logic          p_out, p_oe, n_out, n_oe;    // Pad drives
    logic          p_pin, n_pin, lsd_p, lsd_n;  // Resolved pads, far side levels
    logic [7:0]    ctrl_m;                      // Model of the drive register
    logic          swap_m;                      // Model of the swap register
    int            error_cnt, samples_checked;
    integer        seed = 32'he9d7d66b;

    mpco_pin_override u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .proto_pos_drv(pdrv),
        .proto_neg_drv(ndrv), .proto_pos_level(pp_lvl), .proto_neg_level(pn_lvl),
        .monitored_status_flag(flag), .modem_irq(irq), .power_clock_pos_pin_in(p_pin),
        .power_clock_pos_pin_out(p_out), .power_clock_pos_pin_oe(p_oe),
        .power_clock_neg_pin_in(n_pin), .power_clock_neg_pin_out(n_out),
        .power_clock_neg_pin_oe(n_oe));
    mpco_lsd_model u_lsd (.pos_out(p_out), .pos_oe(p_oe), .neg_out(n_out), .neg_oe(n_oe),
        .lsd_pos(lsd_p), .lsd_neg(lsd_n), .pos_pin(p_pin), .neg_pin(n_pin));

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------------------------------
    // Compare, bus and verdict tasks
    // ------------------------------------
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // One word transfer; read data taken inside the data phase
    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdat);
        @(negedge clk);
        hsel = 1'b1;
        htrans = 2'h2;
        hwrite = wr;
        haddr = {24'h0, addr};
        @(negedge clk);
        hsel = 1'b0;
        htrans = 2'h0;
        hwdata = wdat;
        rd = hrdata;
    endtask : ahb

    // Pads, levels, interrupt and read-back against the model
    task automatic check_all;
        logic [1:0] sp, sn;
        logic       ep_oe, ep_out, en_oe, en_out, lp, ln;
        sp = swap_m ? ctrl_m[5:4] : ctrl_m[7:6];
        sn = swap_m ? ctrl_m[7:6] : ctrl_m[5:4];
        {ep_out, ep_oe} = ctrl_m[1] ? {sp[1], ~sp[0]} : (swap_m ? ndrv : pdrv);
        {en_out, en_oe} = ctrl_m[1] ? {sn[1], ~sn[0]} : (swap_m ? pdrv : ndrv);
        lp = ep_oe ? ep_out : lsd_p;
        ln = en_oe ? en_out : lsd_n;
        cmp("pos_oe", 32'(ep_oe), 32'(p_oe));
        cmp("neg_oe", 32'(en_oe), 32'(n_oe));
        cmp("pos_pin", 32'(lp), 32'(p_pin));
        cmp("neg_pin", 32'(ln), 32'(n_pin));
        cmp("proto_pos_level", 32'(swap_m ? ln : lp), 32'(pp_lvl));
        cmp("proto_neg_level", 32'(swap_m ? lp : ln), 32'(pn_lvl));
        cmp("modem_irq", 32'(flag & ctrl_m[0]), 32'(irq));
        ahb(1'b0, 8'h0c, 32'h0);
        cmp("drive", {24'h0, ctrl_m[7:4], swap_m ? ln : lp, swap_m ? lp : ln, ctrl_m[1:0]}, rd);
        ahb(1'b0, 8'h10, 32'h0);
        cmp("swap", {31'h0, swap_m}, rd);
    endtask : check_all

    task automatic summarize;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // Watchdog against a hung run
    initial begin
        #2000000;
        error_cnt++;
        summarize();
    end

    // ------------------------------------
    // Main sequence: reset, select sweep, random configs, unmapped
    // ------------------------------------
    initial begin
        {rst_n, hsel, hwrite, flag, lsd_p, lsd_n} = 6'h0;
        {haddr, hwdata, htrans, pdrv, ndrv} = '0;
        hready = 1'b1;
        hsize = 3'h2;
        ctrl_m = 8'h02;
        swap_m = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        check_all();
        // Every select pair, direct on and off, both orientations, then random
        for (int i = 0; i < 200; i++) begin
            r = $random(seed);
            wd = (i < 128) ? {r[31:8], i[3:0], 2'h3, i[4], i[5]} : $random(seed);
            ahb(1'b1, 8'h0c, wd);
            ctrl_m = wd[7:0] & 8'hf3;
            ahb(1'b1, 8'h10, {r[31:1], (i < 128) ? i[6] : r[7]});
            swap_m = (i < 128) ? i[6] : r[7];
            {pdrv, ndrv, lsd_p, lsd_n, flag} = r[12:6];
            repeat (6) @(negedge clk);
            check_all();
        end
        // Unmapped place: write ignored, read zero
        ahb(1'b1, 8'h20, 32'hffffffff);
        ahb(1'b0, 8'h20, 32'h0);
        cmp("unmapped", 32'h0, rd);
        repeat (6) @(negedge clk);
        check_all();
        summarize();
    end
endmodule : tb_top
